// ### hw/iajd_pkg.sv
package iajd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int INSTR_W = 16;
   localparam int PC_W = 11;
   localparam int NIB_W = 4;
   localparam int ADDR_W = 7;
   localparam int RAM_DEPTH = 128;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int INC_OP_LSB = 7;
   localparam int BIT0_OP_LSB = 12;
   localparam int JUMP5_OP_LSB = 11;

   // Opcode patterns, aligned to the low end of their fields
   localparam logic [8:0] INC_PATTERN = 9'h0_94;
   localparam logic [3:0] JUMP_ON_BIT0_PATTERN = 4'h8;
   localparam logic [4:0] JUMP_ON_BIT1_PATTERN = 5'h1_2;
   localparam logic [4:0] JUMP_ON_BIT2_PATTERN = 5'h1_4;
   localparam logic [4:0] JUMP_ON_BIT3_PATTERN = 5'h1_6;
   localparam logic [4:0] JUMP_ON_CARRY_PATTERN = 5'h1_E;
   localparam logic [4:0] ABSOLUTE_JUMP_PATTERN = 5'h0_E;
   localparam logic [4:0] JUMP_ON_NO_CARRY_PATTERN = 5'h1_A;
   localparam logic [4:0] JUMP_ON_NONZERO_PATTERN = 5'h1_8;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and arithmetic constants
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [NIB_W-1:0] ACC_RESET = 4'h0;
   localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;
   localparam logic [NIB_W-1:0] NIB_MAX = 4'hF;
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
   localparam logic [PC_W-1:0] PC_ONE = 11'h001;

   // Machine cycles per instruction, one core clock each
   localparam int MACHINE_CYCLES = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction classes handled here
   typedef enum logic [3:0] {
      OP_NONE = 4'b0000,
      OP_INC = 4'b0001,
      OP_JUMP_ON_BIT0 = 4'b0010,
      OP_JUMP_ON_BIT1 = 4'b0011,
      OP_JUMP_ON_BIT2 = 4'b0100,
      OP_JUMP_ON_BIT3 = 4'b0101,
      OP_JUMP_ON_CARRY = 4'b0110,
      OP_ABSOLUTE_JUMP = 4'b0111,
      OP_JUMP_ON_NO_CARRY = 4'b1000,
      OP_JUMP_ON_NONZERO = 4'b1001,
      OP_OTHER = 4'b1010
   } iajd_op_t;

endpackage : iajd_pkg

// ### hw/iajd_data_ram.sv
`timescale 1ns/1ps
module iajd_data_ram (
   input wire logic core_clk_i, // Core clock
   input wire logic we_i, // Write strobe
   input wire logic [iajd_pkg::ADDR_W-1:0] wr_addr_i, // Write address
   input wire logic [iajd_pkg::NIB_W-1:0] wr_data_i, // Write nibble
   input wire logic [iajd_pkg::ADDR_W-1:0] rd_a_addr_i, // Execute read address
   output logic [iajd_pkg::NIB_W-1:0] rd_a_data_o, // Execute read nibble
   input wire logic [iajd_pkg::ADDR_W-1:0] rd_b_addr_i, // Observe read address
   output logic [iajd_pkg::NIB_W-1:0] rd_b_data_o // Observe read nibble
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage; no reset, contents are undefined until written
   logic [iajd_pkg::NIB_W-1:0] mem_q [iajd_pkg::RAM_DEPTH];

   // Write port, one nibble per clock
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // Asynchronous reads so a read-modify-write fits in one clock
   assign rd_a_data_o = mem_q[rd_a_addr_i];
   assign rd_b_data_o = mem_q[rd_b_addr_i];

endmodule : iajd_data_ram

// ### hw/iajd_core.sv
`timescale 1ns/1ps
module iajd_core (
   input wire logic core_clk_i, // Core clock, 200 MHz
   input wire logic rst_i, // Asynchronous reset, active high
   input wire logic [iajd_pkg::INSTR_W-1:0] instr_i, // Instruction word from program memory
   input wire logic instr_valid_i, // Instruction word present this cycle
   input wire logic ext_load_i, // Load accumulator and flags from outside
   input wire logic [iajd_pkg::NIB_W-1:0] ext_acc_i, // Accumulator value to load
   input wire logic ext_carry_i, // Carry value to load
   input wire logic ext_zero_i, // Zero value to load
   input wire logic ext_ram_we_i, // Outside write into data memory
   input wire logic [iajd_pkg::ADDR_W-1:0] ext_ram_addr_i, // Outside write address
   input wire logic [iajd_pkg::NIB_W-1:0] ext_ram_data_i, // Outside write nibble
   input wire logic [iajd_pkg::ADDR_W-1:0] obs_ram_addr_i, // Observation read address
   output logic [iajd_pkg::PC_W-1:0] pc_o, // Program counter
   output logic [iajd_pkg::NIB_W-1:0] working_nibble_reg_o, // Accumulator
   output logic carry_flag_o, // Carry flag
   output logic zero_flag_o, // Zero flag
   output logic exec_done_o, // Pulse: an instruction retired
   output logic jump_taken_o, // Pulse: the retired jump was taken
   output logic unsupported_o, // Pulse: word not handled here, counter advanced
   output logic mem_wr_o, // Pulse: increment wrote data memory
   output logic [iajd_pkg::ADDR_W-1:0] mem_wr_addr_o, // Address of that write
   output logic [iajd_pkg::NIB_W-1:0] mem_wr_data_o, // Nibble of that write
   output logic [iajd_pkg::NIB_W-1:0] obs_ram_data_o // Registered observation nibble
);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Classify one instruction word; patterns do not overlap
   function automatic iajd_pkg::iajd_op_t decode_op(
      input logic [iajd_pkg::INSTR_W-1:0] word,
      input logic valid
   );
      logic [4:0] top5;
      logic [3:0] top4;
      logic [8:0] top9;
      iajd_pkg::iajd_op_t op;
      top5 = word[iajd_pkg::INSTR_W-1:iajd_pkg::JUMP5_OP_LSB];
      top4 = word[iajd_pkg::INSTR_W-1:iajd_pkg::BIT0_OP_LSB];
      top9 = word[iajd_pkg::INSTR_W-1:iajd_pkg::INC_OP_LSB];
      op = iajd_pkg::OP_OTHER;
      if (!valid) begin
         op = iajd_pkg::OP_NONE;
      end else if (top9 == iajd_pkg::INC_PATTERN) begin
         op = iajd_pkg::OP_INC;
      end else if (top4 == iajd_pkg::JUMP_ON_BIT0_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_BIT0;
      end else if (top5 == iajd_pkg::JUMP_ON_BIT1_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_BIT1;
      end else if (top5 == iajd_pkg::JUMP_ON_BIT2_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_BIT2;
      end else if (top5 == iajd_pkg::JUMP_ON_BIT3_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_BIT3;
      end else if (top5 == iajd_pkg::JUMP_ON_CARRY_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_CARRY;
      end else if (top5 == iajd_pkg::ABSOLUTE_JUMP_PATTERN) begin
         op = iajd_pkg::OP_ABSOLUTE_JUMP;
      end else if (top5 == iajd_pkg::JUMP_ON_NO_CARRY_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_NO_CARRY;
      end else if (top5 == iajd_pkg::JUMP_ON_NONZERO_PATTERN) begin
         op = iajd_pkg::OP_JUMP_ON_NONZERO;
      end
      return op;
   endfunction : decode_op

   // Branch condition for each jump class; non-jumps never branch
   function automatic logic jump_cond(
      input iajd_pkg::iajd_op_t op,
      input logic [iajd_pkg::NIB_W-1:0] acc,
      input logic carry
   );
      logic take;
      take = 1'b0;
      unique case (op)
         iajd_pkg::OP_JUMP_ON_BIT0: take = acc[0];
         iajd_pkg::OP_JUMP_ON_BIT1: take = acc[1];
         iajd_pkg::OP_JUMP_ON_BIT2: take = acc[2];
         iajd_pkg::OP_JUMP_ON_BIT3: take = acc[3];
         iajd_pkg::OP_JUMP_ON_CARRY: take = carry;
         iajd_pkg::OP_ABSOLUTE_JUMP: take = 1'b1;
         iajd_pkg::OP_JUMP_ON_NO_CARRY: take = ~carry;
         iajd_pkg::OP_JUMP_ON_NONZERO: take = (acc != iajd_pkg::NIB_ZERO);
         default: take = 1'b0;
      endcase
      return take;
   endfunction : jump_cond

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [iajd_pkg::PC_W-1:0] pc_q;
   logic [iajd_pkg::PC_W-1:0] pc_d;
   logic [iajd_pkg::NIB_W-1:0] acc_q;
   logic [iajd_pkg::NIB_W-1:0] acc_d;
   logic carry_q;
   logic carry_d;
   logic zero_q;
   logic zero_d;
   logic done_q;
   logic taken_q;
   logic unsup_q;
   logic mem_wr_q;
   logic [iajd_pkg::ADDR_W-1:0] mem_wr_addr_q;
   logic [iajd_pkg::NIB_W-1:0] mem_wr_data_q;
   logic [iajd_pkg::NIB_W-1:0] obs_data_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   iajd_pkg::iajd_op_t op_w;
   logic is_inc_w;
   logic is_jump_w;
   logic is_other_w;
   logic take_w;
   logic [iajd_pkg::PC_W-1:0] jump_target_field;
   logic [iajd_pkg::ADDR_W-1:0] memory_address_field;

   // Operand fields sit in the low bits of the word
   assign op_w = decode_op(instr_i, instr_valid_i);
   assign jump_target_field = instr_i[iajd_pkg::PC_W-1:0];
   assign memory_address_field = instr_i[iajd_pkg::ADDR_W-1:0];
   assign is_inc_w = (op_w == iajd_pkg::OP_INC);
   assign is_other_w = (op_w == iajd_pkg::OP_OTHER);
   assign is_jump_w = instr_valid_i & ~is_inc_w & ~is_other_w;
   // Condition uses the state before this instruction retires
   assign take_w = jump_cond(op_w, acc_q, carry_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Increment datapath
   logic [iajd_pkg::NIB_W-1:0] ram_rd_w;
   logic [iajd_pkg::NIB_W-1:0] inc_sum_w;
   logic inc_carry_w;
   logic inc_zero_w;

   // Four-bit sum wraps naturally; carry is the wrap from fifteen
   assign inc_sum_w = ram_rd_w + iajd_pkg::NIB_ONE;
   assign inc_carry_w = (ram_rd_w == iajd_pkg::NIB_MAX);
   assign inc_zero_w = (inc_sum_w == iajd_pkg::NIB_ZERO);

   ////////////////////////////////////////////////////////////////////////////////
   // Data memory write arbitration
   logic ram_we_w;
   logic ext_ram_ok_w;
   logic [iajd_pkg::ADDR_W-1:0] ram_wr_addr_w;
   logic [iajd_pkg::NIB_W-1:0] ram_wr_data_w;

   // The instruction owns the cycle; outside writes only land when idle
   assign ext_ram_ok_w = ext_ram_we_i & ~instr_valid_i;
   assign ram_we_w = is_inc_w | ext_ram_ok_w;
   assign ram_wr_addr_w = is_inc_w ? memory_address_field : ext_ram_addr_i;
   assign ram_wr_data_w = is_inc_w ? inc_sum_w : ext_ram_data_i;

   logic [iajd_pkg::NIB_W-1:0] obs_ram_data_w;

   iajd_data_ram u_data_ram (
      .core_clk_i (core_clk_i),
      .we_i (ram_we_w),
      .wr_addr_i (ram_wr_addr_w),
      .wr_data_i (ram_wr_data_w),
      .rd_a_addr_i (memory_address_field),
      .rd_a_data_o (ram_rd_w),
      .rd_b_addr_i (obs_ram_addr_i),
      .rd_b_data_o (obs_ram_data_w)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next program counter
   logic [iajd_pkg::PC_W-1:0] pc_step_w;

   // Not-taken jumps, the increment and unhandled words all step by one
   assign pc_step_w = pc_q + iajd_pkg::PC_ONE;
   assign pc_d = !instr_valid_i ? pc_q :
                 (is_jump_w & take_w) ? jump_target_field : pc_step_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Next accumulator and flags
   logic ext_ok_w;

   // Outside loads are for idle cycles, so they never fight an increment
   assign ext_ok_w = ext_load_i & ~instr_valid_i;
   assign acc_d = is_inc_w ? inc_sum_w : ext_ok_w ? ext_acc_i : acc_q;
   assign carry_d = is_inc_w ? inc_carry_w : ext_ok_w ? ext_carry_i : carry_q;
   assign zero_d = is_inc_w ? inc_zero_w : ext_ok_w ? ext_zero_i : zero_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Architectural state, one machine cycle per instruction
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_q <= iajd_pkg::PC_RESET;
         acc_q <= iajd_pkg::ACC_RESET;
         carry_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         acc_q <= acc_d;
         carry_q <= carry_d;
         zero_q <= zero_d;
      end
   end

   // Retire strobes, registered so every output comes from a flop
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
         taken_q <= 1'b0;
         unsup_q <= 1'b0;
         mem_wr_q <= 1'b0;
      end else begin
         done_q <= instr_valid_i;
         taken_q <= is_jump_w & take_w;
         unsup_q <= is_other_w;
         mem_wr_q <= is_inc_w;
      end
   end

   // Write report holds between increments; observation data loads every cycle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_wr_addr_q <= {iajd_pkg::ADDR_W{1'b0}};
         mem_wr_data_q <= iajd_pkg::NIB_ZERO;
         obs_data_q <= iajd_pkg::NIB_ZERO;
      end else begin
         if (is_inc_w) begin
            mem_wr_addr_q <= memory_address_field;
            mem_wr_data_q <= inc_sum_w;
         end
         obs_data_q <= obs_ram_data_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign pc_o = pc_q;
   assign working_nibble_reg_o = acc_q;
   assign carry_flag_o = carry_q;
   assign zero_flag_o = zero_q;
   assign exec_done_o = done_q;
   assign jump_taken_o = taken_q;
   assign unsupported_o = unsup_q;
   assign mem_wr_o = mem_wr_q;
   assign mem_wr_addr_o = mem_wr_addr_q;
   assign mem_wr_data_o = mem_wr_data_q;
   assign obs_ram_data_o = obs_data_q;

endmodule : iajd_core

// ### dv/iajd_properties.sv
`timescale 1ns/1ps
// Retire timing, jump targets and increment results seen from the pins
module iajd_props (
   input wire logic core_clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic [15:0] instr_i, // Word
   input wire logic instr_valid_i, // Word valid
   input wire logic [10:0] pc_o, // Counter
   input wire logic [3:0] working_nibble_reg_o, // Accumulator
   input wire logic carry_flag_o, // Carry
   input wire logic zero_flag_o, // Zero
   input wire logic exec_done_o, // Retire pulse
   input wire logic jump_taken_o, // Taken pulse
   input wire logic unsupported_o, // Unhandled pulse
   input wire logic mem_wr_o, // Increment write
   input wire logic [6:0] mem_wr_addr_o, // Increment address
   input wire logic [3:0] mem_wr_data_o // Increment nibble
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Own decode, so a slip in the design's tables is not copied here
   wire [4:0] top5 = instr_i[15:11];
   wire [10:0] tgt = instr_i[10:0];
   wire [6:0] adr = instr_i[6:0];
   wire [3:0] acc = working_nibble_reg_o;
   wire is_b0 = instr_i[15:12] == 4'h8;
   wire jv = instr_valid_i && (is_b0 || top5 inside {5'h12, 5'h14, 5'h16, 5'h1E, 5'h0E,
      5'h1A, 5'h18});
   wire iv = instr_valid_i && instr_i[15:7] == 9'h094;
   wire cond = is_b0 ? acc[0] : top5 == 5'h12 ? acc[1] : top5 == 5'h14 ? acc[2] :
      top5 == 5'h16 ? acc[3] : top5 == 5'h1E ? carry_flag_o :
      top5 == 5'h1A ? !carry_flag_o : top5 == 5'h18 ? acc != 4'h0 : 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   retire_one_cycle_a:
   assert property (instr_valid_i |=> exec_done_o) else $error("no retire after word");
   jump_pc_value_a:
   assert property (jv |=> pc_o == ($past(cond) ? $past(tgt) : $past(pc_o) + 11'h001))
      else $error("jump counter wrong");
   taken_flag_a:
   assert property (jv |=> jump_taken_o == $past(cond) && !unsupported_o)
      else $error("taken pulse wrong");
   idle_hold_a:
   assert property (!instr_valid_i |=> $stable(pc_o) && !exec_done_o)
      else $error("idle cycle moved");
   inc_write_a:
   assert property (iv |=> mem_wr_o && mem_wr_addr_o == $past(adr) && pc_o == $past(pc_o) + 11'h001)
      else $error("increment write wrong");
   inc_acc_copy_a:
   assert property (iv |=> working_nibble_reg_o == mem_wr_data_o && !jump_taken_o)
      else $error("accumulator not the stored sum");
   inc_flags_a:
   assert property (iv |=> zero_flag_o == (acc == 4'h0) && carry_flag_o == (acc == 4'h0))
      else $error("increment flags wrong");
   other_word_a:
   assert property (instr_valid_i && !jv && !iv |=> unsupported_o && pc_o == $past(pc_o) + 11'h001)
      else $error("unhandled word wrong");
   cover property (jv && cond);
   cover property (jv && !cond);
   cover property (iv ##1 iv);
endmodule : iajd_props

// ### dv/iajd_prog_mem.sv
`timescale 1ns/1ps
// Program memory: bench writes words, the core fetches at its counter with no latency
module iajd_prog_mem (
   input wire logic core_clk_i, // Clock
   input wire logic we_i, // Write strobe
   input wire logic [10:0] wr_addr_i, // Write address
   input wire logic [15:0] wr_data_i, // Write word
   input wire logic [10:0] rd_addr_i, // Fetch address
   output logic [15:0] rd_data_o // Fetched word
);
   logic [15:0] mem_q [2048];
   // Unwritten words read all ones, which no handled opcode matches
   initial begin
      foreach (mem_q[i]) begin
         mem_q[i] = 16'hFFFF;
      end
   end
   // Plain always, since the initial block also writes the array
   always @(posedge core_clk_i) begin
      if (we_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end
   assign rd_data_o = mem_q[rd_addr_i];
endmodule : iajd_prog_mem

// ### dv/increment_and_jump_decode_test.sv
`timescale 1ns/1ps
module increment_and_jump_decode_test;
   // Row: loaded accumulator and carry, word, expected taken
   typedef struct packed {
      logic [3:0] acc;
      logic c;
      logic [15:0] w;
      logic tk;
   } iajd_row_t;
   localparam iajd_row_t ROWS [16] = '{
      '{4'h1, 1'h0, 16'h8FFF, 1'h1}, '{4'hE, 1'h0, 16'h8123, 1'h0},
      '{4'h2, 1'h0, 16'h9055, 1'h1}, '{4'hD, 1'h1, 16'h9066, 1'h0},
      '{4'h4, 1'h0, 16'hA077, 1'h1}, '{4'hB, 1'h1, 16'hA088, 1'h0},
      '{4'h8, 1'h0, 16'hB099, 1'h1}, '{4'h7, 1'h1, 16'hB0AA, 1'h0},
      '{4'h0, 1'h1, 16'hF0BB, 1'h1}, '{4'hF, 1'h0, 16'hF0CC, 1'h0},
      '{4'h0, 1'h0, 16'hD0DD, 1'h1}, '{4'h0, 1'h1, 16'hD0EE, 1'h0},
      '{4'h1, 1'h0, 16'hC111, 1'h1}, '{4'h0, 1'h1, 16'hC222, 1'h0},
      '{4'h0, 1'h0, 16'h7333, 1'h1}, '{4'hF, 1'h1, 16'h7444, 1'h1}};
   logic core_clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic instr_valid_i = 1'h0;
   logic ext_load_i = 1'h0;
   logic [3:0] ext_acc_i = 4'h0;
   logic ext_carry_i = 1'h0;
   logic ext_zero_i = 1'h0;
   logic ext_ram_we_i = 1'h0;
   logic [6:0] ext_ram_addr_i = 7'h00;
   logic [3:0] ext_ram_data_i = 4'h0;
   logic [6:0] obs_ram_addr_i = 7'h00;
   logic pm_we = 1'h0;
   logic [10:0] pm_addr = 11'h000;
   logic [15:0] pm_data = 16'h0000;
   logic [15:0] instr_i;
   logic [10:0] pc_o;
   logic [3:0] working_nibble_reg_o, mem_wr_data_o, obs_ram_data_o;
   logic carry_flag_o, zero_flag_o, exec_done_o, jump_taken_o, unsupported_o, mem_wr_o;
   logic [6:0] mem_wr_addr_o;
   logic [10:0] exp_pc = 11'h000;
   int fails = 0;
   int n_tests = 0;
   always #2.5 core_clk_i = ~core_clk_i;
   iajd_core u_dut (.core_clk_i, .rst_i, .instr_i, .instr_valid_i, .ext_load_i, .ext_acc_i,
      .ext_carry_i, .ext_zero_i, .ext_ram_we_i, .ext_ram_addr_i, .ext_ram_data_i,
      .obs_ram_addr_i, .pc_o, .working_nibble_reg_o, .carry_flag_o, .zero_flag_o, .exec_done_o,
      .jump_taken_o, .unsupported_o, .mem_wr_o, .mem_wr_addr_o, .mem_wr_data_o, .obs_ram_data_o);
   iajd_prog_mem u_mem (.core_clk_i, .we_i(pm_we), .wr_addr_i(pm_addr), .wr_data_i(pm_data),
      .rd_addr_i(pc_o), .rd_data_o(instr_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Loads state and stores a word in one cycle; valid stays low so the load lands
   task automatic prep(input logic [3:0] a, input logic c, input logic [10:0] ad,
      input logic [15:0] w);
      @(posedge core_clk_i);
      ext_load_i <= 1'h1;
      ext_acc_i <= a;
      ext_carry_i <= c;
      ext_zero_i <= (a == 4'h0);
      pm_we <= 1'h1;
      pm_addr <= ad;
      pm_data <= w;
      @(posedge core_clk_i);
      ext_load_i <= 1'h0;
      pm_we <= 1'h0;
   endtask : prep
   task automatic wram(input logic [6:0] ad, input logic [3:0] d);
      @(posedge core_clk_i);
      ext_ram_we_i <= 1'h1;
      ext_ram_addr_i <= ad;
      ext_ram_data_i <= d;
      @(posedge core_clk_i);
      ext_ram_we_i <= 1'h0;
   endtask : wram
   // Valid for n back-to-back cycles, then look one step after the last edge
   task automatic fire(input int n);
      @(posedge core_clk_i);
      instr_valid_i <= 1'h1;
      repeat (n) @(posedge core_clk_i);
      instr_valid_i <= 1'h0;
      #1;
   endtask : fire
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: table of jumps, then hand cases
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'h0;
      #1;
      chk({pc_o, carry_flag_o, zero_flag_o, exec_done_o, jump_taken_o, unsupported_o}, 16'h0000);
      // First row jumps to the top address, so the second shows the 11-bit wrap
      foreach (ROWS[i]) begin
         prep(ROWS[i].acc, ROWS[i].c, exp_pc, ROWS[i].w);
         fire(1);
         exp_pc = ROWS[i].tk ? ROWS[i].w[10:0] : exp_pc + 11'h001;
         chk({pc_o, exec_done_o, jump_taken_o, 3'h0}, {exp_pc, 1'h1, ROWS[i].tk, 3'h0});
      end
      // Zero-accumulator jump is not handled here and must not be taken
      prep(4'h0, 1'h0, exp_pc, 16'hE010);
      fire(1);
      exp_pc = exp_pc + 11'h001;
      chk({pc_o, unsupported_o, jump_taken_o, 3'h0}, {exp_pc, 1'h1, 1'h0, 3'h0});
      // Wrap of a full nibble, then two back-to-back on one location
      wram(7'h05, 4'hF);
      wram(7'h06, 4'h3);
      prep(4'h0, 1'h0, exp_pc, 16'h4A05);
      prep(4'h0, 1'h0, exp_pc + 11'h001, 16'h4A06);
      prep(4'h0, 1'h0, exp_pc + 11'h002, 16'h4A06);
      fire(1);
      chk({working_nibble_reg_o, carry_flag_o, zero_flag_o, mem_wr_o, mem_wr_addr_o, 2'h0},
         {4'h0, 1'h1, 1'h1, 1'h1, 7'h05, 2'h0});
      fire(2);
      exp_pc = exp_pc + 11'h003;
      chk({working_nibble_reg_o, carry_flag_o, zero_flag_o, mem_wr_o, mem_wr_addr_o, 2'h0},
         {4'h5, 1'h0, 1'h0, 1'h1, 7'h06, 2'h0});
      chk({mem_wr_data_o, 1'h0, pc_o}, {4'h5, 1'h0, exp_pc});
      @(posedge core_clk_i);
      obs_ram_addr_i <= 7'h05;
      repeat (2) @(posedge core_clk_i);
      #1;
      chk({12'h000, obs_ram_data_o}, 16'h0000);
      // Second location carries the two chained increments
      @(posedge core_clk_i);
      obs_ram_addr_i <= 7'h06;
      repeat (2) @(posedge core_clk_i);
      #1;
      chk({12'h000, obs_ram_data_o}, 16'h0005);
      // Reset in mid-run clears the counter
      @(posedge core_clk_i);
      rst_i <= 1'h1;
      @(posedge core_clk_i);
      rst_i <= 1'h0;
      #1;
      chk({1'h0, working_nibble_reg_o, pc_o}, 16'h0000);
      print_verdict();
   end
   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge core_clk_i);
      fails++;
      print_verdict();
   end
endmodule : increment_and_jump_decode_test
bind iajd_core iajd_props u_props (.core_clk_i, .rst_i, .instr_i, .instr_valid_i, .pc_o,
   .working_nibble_reg_o, .carry_flag_o, .zero_flag_o, .exec_done_o, .jump_taken_o,
   .unsupported_o, .mem_wr_o, .mem_wr_addr_o, .mem_wr_data_o);
